// [hw/mrad_cfg.svh]
// Constants for the remap interrupt address decoder: field positions and fixed patterns.
// Assumes inclusion by bare name from the package and the decoder module.
`ifndef MRAD_CFG_SVH
`define MRAD_CFG_SVH

// Fixed address pattern in the top twelve bits
`define MRAD_PAT_HI 31
`define MRAD_PAT_LO 20
`define MRAD_PAT_VAL 12'hfee
// Low two bits must be zero
`define MRAD_LOW_HI 1
`define MRAD_LOW_LO 0
`define MRAD_LOW_VAL 2'h0
// Lower fifteen handle bits
`define MRAD_HLO_HI 19
`define MRAD_HLO_LO 5
// Format, sub-handle-valid and top handle bit positions
`define MRAD_FMT_BIT 4
`define MRAD_SHV_BIT 3
`define MRAD_HTOP_BIT 2
// Part of the data word added as sub-handle
`define MRAD_SUB_HI 15
`define MRAD_SUB_LO 0

`endif

// [hw/mrad_pkg.sv]
// Types for the remap interrupt address decoder.
// Assumes the constant header is on the include path.
`include "mrad_cfg.svh"

package mrad_pkg;

  // Decoder sequencing
  typedef enum logic [0:0] {
    MRAD_IDLE = 1'b0,
    MRAD_LOOKUP = 1'b1
  } mrad_state_t;

  // Whole state of the decoder
  typedef struct packed {
    mrad_state_t st;
    logic lk_valid;
    logic [15:0] lk_offset;
    logic [15:0] lk_handle;
    logic lk_sub_valid;
    logic cp_valid;
    logic [31:0] cp_addr;
    logic [31:0] cp_data;
    logic addr_err;
  } mrad_regs_t;

endpackage

// [hw/mrad_decoder.sv]
// Remap interrupt address decoder: checks an interrupt message write and forms the
// remapping table offset, or passes the message on as a compatibility interrupt.
// Assumes requesters hold msg_valid with stable address and data until msg_ready,
// and the table side accepts a lookup with lookup_ready.
// Limitation: one lookup outstanding, so remaps run at best one per two cycles.
// Trade-off: no buffering; the requester waits while the table side stalls.
`timescale 1ns/10ps
`default_nettype none
`include "mrad_cfg.svh"

module mrad_decoder
  import mrad_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [31:0] msg_addr,
  input wire logic [31:0] msg_data,
  output logic lookup_valid,
  input wire logic lookup_ready,
  output logic [15:0] lookup_offset,
  output logic [15:0] lookup_handle,
  output logic lookup_sub_valid,
  output logic compat_valid,
  output logic [31:0] compat_addr,
  output logic [31:0] compat_data,
  output logic addr_err
);

  mrad_regs_t state_r;
  mrad_regs_t state_nxt;
  logic pattern_ok;
  logic fmt_remap;
  logic sub_valid;
  logic [15:0] handle;
  logic [15:0] sub_handle;
  logic take;

  // Field extraction from the incoming address
  // Pattern is checked for both formats, so a bad compatibility write is dropped too
  assign pattern_ok = (msg_addr[`MRAD_PAT_HI:`MRAD_PAT_LO] == `MRAD_PAT_VAL) &&
                      (msg_addr[`MRAD_LOW_HI:`MRAD_LOW_LO] == `MRAD_LOW_VAL);
  assign fmt_remap = msg_addr[`MRAD_FMT_BIT];
  assign sub_valid = msg_addr[`MRAD_SHV_BIT];
  assign handle = {msg_addr[`MRAD_HTOP_BIT],
                   msg_addr[`MRAD_HLO_HI:`MRAD_HLO_LO]};
  assign sub_handle = msg_data[`MRAD_SUB_HI:`MRAD_SUB_LO];

  // One message at a time; a pending lookup stalls the requester
  assign msg_ready = (state_r.st == MRAD_IDLE);
  assign take = msg_valid && msg_ready;

  // Next-state logic
  // A bad pattern wins over the format bit, so it never starts a lookup
  always_comb begin
    state_nxt = state_r;
    state_nxt.cp_valid = 1'b0;
    state_nxt.addr_err = 1'b0;
    case (state_r.st)
      MRAD_IDLE: begin
        if (take) begin
          if (!pattern_ok) begin
            // Not a valid interrupt address: flag and drop it
            state_nxt.addr_err = 1'b1;
          end else if (fmt_remap) begin
            state_nxt.st = MRAD_LOOKUP;
            state_nxt.lk_valid = 1'b1;
            state_nxt.lk_handle = handle;
            state_nxt.lk_sub_valid = sub_valid;
            // Sum wraps at sixteen bits; an overflowing sub-handle lands low in the table
            if (sub_valid) begin
              state_nxt.lk_offset = 16'(handle + sub_handle);
            end else begin
              state_nxt.lk_offset = handle;
            end
          end else begin
            // Compatibility format bypasses the table
            state_nxt.cp_valid = 1'b1;
            state_nxt.cp_addr = msg_addr;
            state_nxt.cp_data = msg_data;
          end
        end
      end
      MRAD_LOOKUP: begin
        // Offset stays put until the table side takes it
        if (lookup_ready) begin
          state_nxt.st = MRAD_IDLE;
          state_nxt.lk_valid = 1'b0;
        end
      end
      default: begin
        // Unreachable with a one-bit state; kept so a stray code falls back to idle
        state_nxt.st = MRAD_IDLE;
        state_nxt.lk_valid = 1'b0;
      end
    endcase
  end

  // State register
  // Reset withdraws a pending lookup; the table side sees valid drop at once
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state flops
  // Every data output is a flop, so nothing combinational reaches the table side
  assign lookup_valid = state_r.lk_valid;
  assign lookup_offset = state_r.lk_offset;
  assign lookup_handle = state_r.lk_handle;
  assign lookup_sub_valid = state_r.lk_sub_valid;
  assign compat_valid = state_r.cp_valid;
  assign compat_addr = state_r.cp_addr;
  assign compat_data = state_r.cp_data;
  assign addr_err = state_r.addr_err;

  // Checks on the decoder's own outputs
  default clocking mrad_cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  chk_bad_pattern: assert property (
    (take && ((msg_addr[31:20] != 12'hfee) || (msg_addr[1:0] != 2'h0)))
    |=> addr_err && !compat_valid && !$rose(lookup_valid))
    else $error("Bad address pattern not flagged");

  chk_handle_low: assert property (
    $rose(lookup_valid) |-> lookup_handle[14:0] == $past(msg_addr[19:5]))
    else $error("Handle low bits wrong");

  chk_handle_top: assert property (
    $rose(lookup_valid) |-> lookup_handle[15] == $past(msg_addr[2]))
    else $error("Handle top bit wrong");

  chk_sub_add: assert property (
    ($rose(lookup_valid) && lookup_sub_valid)
    |-> lookup_offset == 16'(lookup_handle + $past(msg_data[15:0])))
    else $error("Sub-handle offset wrong");

  chk_plain_offset: assert property (
    ($rose(lookup_valid) && !lookup_sub_valid) |-> lookup_offset == lookup_handle)
    else $error("Plain offset differs from handle");

  chk_compat_path: assert property (
    (take && pattern_ok && !msg_addr[4])
    |=> compat_valid && !$rose(lookup_valid) && compat_addr == $past(msg_addr))
    else $error("Compatibility message misrouted");

  chk_lookup_hold: assert property (
    (lookup_valid && !lookup_ready) |=> lookup_valid && $stable(lookup_offset) && !msg_ready)
    else $error("Lookup dropped before accept");

  chk_lookup_done: assert property (
    (lookup_valid && lookup_ready) |=> !lookup_valid && msg_ready)
    else $error("Lookup not released");

  // Exactly one answer per taken message, and none without one
  chk_one_answer: assert property (
    take |=> $onehot({addr_err, compat_valid, lookup_valid}))
    else $error("Taken message gave no single answer");

  chk_no_answer: assert property (
    !take |=> !addr_err && !compat_valid && !$rose(lookup_valid))
    else $error("Answer without a taken message");

  // Remap entry and the sub-handle flag copied from the address
  chk_remap_entry: assert property (
    (take && pattern_ok && msg_addr[4])
    |=> lookup_valid && lookup_sub_valid == $past(msg_addr[3]))
    else $error("Remap message did not start a lookup");

  // Offsets rebuilt from the raw address, independent of the handle output
  chk_offset_raw: assert property (
    ($rose(lookup_valid) && !lookup_sub_valid)
    |-> lookup_offset == {$past(msg_addr[2]), $past(msg_addr[19:5])})
    else $error("Plain offset not the raw handle");

  chk_sum_raw: assert property (
    ($rose(lookup_valid) && lookup_sub_valid)
    |-> lookup_offset == 16'({$past(msg_addr[2]), $past(msg_addr[19:5])} +
                             $past(msg_data[15:0])))
    else $error("Summed offset not raw handle plus data");

  chk_compat_data: assert property (
    (take && pattern_ok && !msg_addr[4]) |=> compat_data == $past(msg_data))
    else $error("Compatibility data wrong");

  // Compatibility copy and finished lookup fields keep their last values
  chk_compat_hold: assert property (
    !take |=> $stable(compat_addr) && $stable(compat_data))
    else $error("Compatibility copy changed without a message");

  chk_lookup_keep: assert property (
    (lookup_valid && lookup_ready) |=> $stable(lookup_offset) && $stable(lookup_handle))
    else $error("Lookup fields changed at release");

  // Ready is the exact inverse of a pending lookup
  chk_ready_idle: assert property (
    msg_ready != lookup_valid)
    else $error("Ready and pending lookup disagree");

  // Main scenarios the bench should reach
  cov_remap_sub: cover property ($rose(lookup_valid) && lookup_sub_valid);
  cov_remap_plain: cover property ($rose(lookup_valid) && !lookup_sub_valid);
  cov_compat: cover property (compat_valid);
  cov_error: cover property (addr_err);
  cov_stall_release: cover property (lookup_valid && !lookup_ready ##1 lookup_valid && lookup_ready);

endmodule

`default_nettype wire

// [tb/mrad_requester.sv]
// Requester model: forms interrupt message writes and posts them to the decoder.
// Assumes the decoder samples on the rising edge of core_clk.
`timescale 1ns/10ps
`default_nettype none
module mrad_requester (
  input wire logic core_clk,
  input wire logic msg_ready,
  output logic msg_valid,
  output logic [31:0] msg_addr,
  output logic [31:0] msg_data
);
  logic [31:0] sent_addr;
  initial begin
    msg_valid = 1'b0;
    msg_addr = 32'h0;
    msg_data = 32'h0;
  end
  // Hold the write until taken, then invert the lines so stale values never match
  task automatic send(input logic fmt, input logic shv, input logic [15:0] h,
    input logic [31:0] d, input logic [1:0] bad);
    @(posedge core_clk);
    // bad[1] spoils the top pattern, bad[0] sets a low address bit
    sent_addr = {bad[1] ? 12'hfef : 12'hfee, h[14:0], fmt, shv, h[15],
                 1'b0, bad[0]};
    msg_addr <= sent_addr;
    msg_data <= d;
    msg_valid <= 1'b1;
    do @(posedge core_clk); while (msg_ready !== 1'b1);
    msg_valid <= 1'b0;
    msg_addr <= ~sent_addr;
    msg_data <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/mrad_decoder_tb.sv]
// Bench for the remap interrupt address decoder: remap, compat and bad-pattern writes.
// Assumes the requester model in mrad_requester.
`timescale 1ns/10ps
`default_nettype none
module mrad_decoder_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic lookup_ready = 1'b0;
  logic msg_valid, msg_ready, lookup_valid, lookup_sub_valid, compat_valid, addr_err;
  logic [31:0] msg_addr, msg_data, compat_addr, compat_data;
  logic [15:0] lookup_offset, lookup_handle;
  int miscompares = 0;
  int num_checks = 0;
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  mrad_decoder u_mrad_decoder (.core_clk(core_clk), .arst_n(arst_n), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_addr(msg_addr), .msg_data(msg_data),
    .lookup_valid(lookup_valid), .lookup_ready(lookup_ready),
    .lookup_offset(lookup_offset), .lookup_handle(lookup_handle),
    .lookup_sub_valid(lookup_sub_valid), .compat_valid(compat_valid),
    .compat_addr(compat_addr), .compat_data(compat_data), .addr_err(addr_err));
  mrad_requester u_mrad_requester (.core_clk(core_clk), .msg_ready(msg_ready),
    .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Remap write; the table stalls so the lookup must hold its value
  task automatic remap(input logic shv, input logic [15:0] h, input logic [31:0] d);
    u_mrad_requester.send(1'b1, shv, h, d, 2'b00);
    #1;
    check("lookup_valid", 32'(lookup_valid), 32'h1);
    check("lookup_handle", 32'(lookup_handle), 32'(h));
    check("lookup_sub_valid", 32'(lookup_sub_valid), 32'(shv));
    check("lookup_offset", 32'(lookup_offset), 32'(shv ? 16'(h + d[15:0]) : h));
    check("stall_ready", 32'(msg_ready), 32'h0);
    repeat (3) @(posedge core_clk);
    lookup_ready <= 1'b1;
    @(posedge core_clk);
    lookup_ready <= 1'b0;
    #1;
    check("lookup_done", 32'(lookup_valid), 32'h0);
    $display("remap test done");
  endtask
  // Reset while a lookup waits: the pending lookup must be withdrawn at once
  task automatic reset_mid();
    u_mrad_requester.send(1'b1, 1'b0, 16'h0123, 32'h0, 2'b00);
    #1;
    check("pend_lookup", 32'(lookup_valid), 32'h1);
    @(posedge core_clk);
    arst_n <= 1'b0;
    #1;
    check("rst_lookup_valid", 32'(lookup_valid), 32'h0);
    check("rst_msg_ready", 32'(msg_ready), 32'h1);
    @(posedge core_clk);
    arst_n <= 1'b1;
    $display("reset test done");
  endtask
  task automatic compat();
    u_mrad_requester.send(1'b0, 1'b1, 16'h8421, 32'h1234_5678, 2'b00);
    #1;
    check("compat_valid", 32'(compat_valid), 32'h1);
    check("no_lookup", 32'(lookup_valid), 32'h0);
    check("compat_addr", compat_addr, u_mrad_requester.sent_addr);
    check("compat_data", compat_data, 32'h1234_5678);
    $display("compat test done");
  endtask
  // Bad top pattern on a remap write, then a low bit set on a compatibility write
  task automatic bad_pattern();
    u_mrad_requester.send(1'b1, 1'b0, 16'h0001, 32'h0, 2'b10);
    #1;
    check("addr_err", 32'(addr_err), 32'h1);
    check("err_no_lookup", 32'(lookup_valid), 32'h0);
    u_mrad_requester.send(1'b0, 1'b0, 16'h0002, 32'h0, 2'b01);
    #1;
    check("low_bits_err", 32'(addr_err), 32'h1);
    check("err_no_compat", 32'(compat_valid), 32'h0);
    $display("error test done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    remap(1'b0, 16'h8005, 32'hffff_0003);
    remap(1'b1, 16'hfff0, 32'hffff_0020);
    reset_mid();
    compat();
    bad_pattern();
    print_verdict();
  end
  // Watchdog: the tests need well under 100 cycles
  initial begin
    repeat (500) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
